//--- uof_pkg.sv
// Constants, types and the behaviour list of the UDMA overrun flag block
// Contract
// - A 6-byte holding buffer apart from the sector FIFO catches data during a read pause.
// - Holding-overflow flag sets when more than 6 bytes enter the holding buffer.
// - Holding-overflow flag is status bit 4, resets to 0, works in all non-manual modes.
// - On reads, a full sector FIFO before the byte count is reached feeds the buffer.
// - On writes, the flag sets only if a drive stop request is not honoured.
// - In PIO or multiword DMA the holding-overflow flag only flags a logic fault; the code sets it there on any holding overflow or unhonoured stop.
// - Soft reset or start-transfer control clears the holding-overflow flag.
// - Sync-buffer receive error flag is status bit 5, resets to 0, UDMA reads only.
// - Sync-buffer receive error flag sets when the receive sync buffer overruns.
// - Soft reset or start-transfer control clears the sync-buffer receive error flag.
// - Receive-surplus flag is status bit 6, resets to 0, UDMA reads only.
// - Receive-surplus flag sets when drive data arrives after the expected byte count.
// - Surplus data is counted in 2-byte words in a readable count register.
// - Surplus bytes are dropped at once, never reaching the FIFO or holding buffer.
// - UDMA CRC keeps accumulating over surplus words until the read burst terminates.
// - A drive that sent surplus then stopped at termination sees no CRC error.
package uof_pkg;
  localparam int WORD_W = 16;
  localparam int WORD_BYTES = 2;
  localparam int HOLD_BYTES = 6;
  localparam int HOLD_DEPTH = HOLD_BYTES / WORD_BYTES;
  localparam int LEVEL_W = 2;
  localparam int BCNT_W = 24;
  localparam int SURPLUS_W = 8;
  localparam int STAT_W = 8;
  localparam int BIT_HOLD_OVF = 4;
  localparam int BIT_SYNC_ERR = 5;
  localparam int BIT_SURPLUS = 6;
  localparam int BIT_RSVD = 7;
  localparam logic [LEVEL_W-1:0] LEVEL_EMPTY = 2'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE = 2'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 2'h3;
  localparam logic [LEVEL_W-1:0] SLOT_LAST = 2'h2;
  localparam logic [BCNT_W-1:0] BCNT_STEP = 24'h000002;
  localparam logic [BCNT_W-1:0] BCNT_ZERO = 24'h000000;
  localparam logic [SURPLUS_W-1:0] SURPLUS_ZERO = 8'h00;
  localparam logic [SURPLUS_W-1:0] SURPLUS_ONE = 8'h01;
  localparam logic [SURPLUS_W-1:0] SURPLUS_MAX = 8'hFF;
  localparam logic [2:0] WSPILL_ZERO = 3'h0;
  localparam logic [2:0] WSPILL_ONE = 3'h1;
  localparam logic [2:0] WSPILL_LIMIT = 3'h3;
  localparam logic [WORD_W-1:0] CRC_SEED = 16'h4ABA;
  localparam logic [WORD_W-1:0] CRC_POLY = 16'h1021;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic RSVD_VALUE = 1'b0;
  localparam logic [3:0] LOW_BITS_VALUE = 4'h0;
  typedef enum logic [1:0] {UOF_MANUAL, UOF_PIO, UOF_MWDMA, UOF_UDMA} uof_mode_t;
  typedef enum logic [1:0] {UOF_IDLE, UOF_RUN, UOF_ENDED} uof_xfer_t;
endpackage

//--- uof_hold_if.sv
// Signals between the flag logic and its holding buffer
`timescale 1ns/100ps
interface uof_hold_if;
  import uof_pkg::*;
  logic push;
  logic [WORD_W-1:0] push_data;
  logic pop;
  logic clear;
  logic [WORD_W-1:0] head_data;
  logic head_ok;
  logic [LEVEL_W-1:0] level;
  modport owner (output push, push_data, pop, clear, input head_data, head_ok, level);
  modport store (input push, push_data, pop, clear, output head_data, head_ok, level);
endinterface

//--- uof_hold_buf.sv
// Three-word holding buffer with a registered head word
`timescale 1ns/100ps
module uof_hold_buf (
  input wire logic clk,
  input wire logic rst,
  uof_hold_if.store hb
);
  import uof_pkg::*;

  logic [WORD_W-1:0] mem_r [HOLD_DEPTH];
  logic [LEVEL_W-1:0] wr_ptr_r;
  logic [LEVEL_W-1:0] rd_ptr_r;
  logic [LEVEL_W-1:0] level_r;
  logic [LEVEL_W-1:0] level_nxt;
  logic [WORD_W-1:0] head_r;
  logic head_ok_r;

  function automatic logic [LEVEL_W-1:0] ptr_inc(input logic [LEVEL_W-1:0] p);
    ptr_inc = (p == SLOT_LAST) ? LEVEL_EMPTY : p + LEVEL_ONE;
  endfunction

  wire do_push = hb.push && (level_r != LEVEL_FULL);
  wire do_pop = hb.pop && head_ok_r;
  assign level_nxt = hb.clear ? LEVEL_EMPTY :
                     (do_push && !do_pop) ? level_r + LEVEL_ONE :
                     (!do_push && do_pop) ? level_r - LEVEL_ONE : level_r;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= hb.push_data;
    end
  end

  // Head word is valid only once it has sat one cycle without a pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= LEVEL_EMPTY;
      rd_ptr_r <= LEVEL_EMPTY;
      level_r <= LEVEL_EMPTY;
      head_r <= WORD_ZERO;
      head_ok_r <= 1'b0;
    end else begin
      wr_ptr_r <= hb.clear ? LEVEL_EMPTY : (do_push ? ptr_inc(wr_ptr_r) : wr_ptr_r);
      rd_ptr_r <= hb.clear ? LEVEL_EMPTY : (do_pop ? ptr_inc(rd_ptr_r) : rd_ptr_r);
      level_r <= level_nxt;
      head_r <= mem_r[rd_ptr_r];
      head_ok_r <= (level_r != LEVEL_EMPTY) && !do_pop && !hb.clear;
    end
  end

  assign hb.head_data = head_r;
  assign hb.head_ok = head_ok_r;
  assign hb.level = level_r;

  a_level_count: assert property (@(posedge clk) disable iff (rst)
    do_push && !do_pop && !hb.clear |=> level_r == $past(level_r) + LEVEL_ONE)
    else $error("holding level did not count a pushed word");
endmodule

//--- uof_flags.sv
// Overrun, sync-buffer and surplus flags of the automatic transfer path
`timescale 1ns/100ps
module uof_flags (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset_set,
  input wire logic begin_auto_transfer,
  input wire uof_pkg::uof_mode_t xfer_mode,
  input wire logic xfer_is_read,
  input wire logic [uof_pkg::BCNT_W-1:0] expected_bytes,
  input wire logic rx_valid,
  input wire logic [uof_pkg::WORD_W-1:0] rx_word,
  input wire logic sector_fifo_full,
  input wire logic sync_buffer_overrun,
  input wire logic drive_stop_request,
  input wire logic tx_word_strobe,
  input wire logic udma_burst_end,
  input wire logic [uof_pkg::WORD_W-1:0] drive_crc,
  output logic sector_fifo_wr,
  output logic [uof_pkg::WORD_W-1:0] sector_fifo_wr_data,
  output logic [uof_pkg::STAT_W-1:0] transfer_error_status,
  output logic [uof_pkg::SURPLUS_W-1:0] surplus_word_count,
  output logic crc_error
);
  import uof_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers

  uof_xfer_t state_r;
  uof_xfer_t state_nxt;
  logic [BCNT_W-1:0] remain_r;
  logic [BCNT_W-1:0] remain_nxt;
  logic [WORD_W-1:0] crc_r;
  logic [WORD_W-1:0] crc_nxt;
  logic crc_error_r;
  logic crc_error_nxt;
  logic hold_ovf_r;
  logic hold_ovf_nxt;
  logic sync_err_r;
  logic sync_err_nxt;
  logic surplus_r;
  logic surplus_nxt;
  logic [SURPLUS_W-1:0] surplus_cnt_r;
  logic [SURPLUS_W-1:0] surplus_cnt_nxt;
  logic stop_seen_r;
  logic stop_seen_nxt;
  logic [2:0] spill_cnt_r;
  logic [2:0] spill_cnt_nxt;
  logic fifo_wr_r;
  logic [WORD_W-1:0] fifo_data_r;

  uof_hold_if hb ();

  uof_hold_buf u_hold (
    .clk(clk),
    .rst(rst),
    .hb(hb.store)
  );

  // UDMA CRC, x^16 + x^12 + x^5 + 1, one word per call
  function automatic logic [WORD_W-1:0] crc_word(
    input logic [WORD_W-1:0] crc,
    input logic [WORD_W-1:0] data
  );
    logic [WORD_W-1:0] c;
    c = crc;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      c = (c[WORD_W-1] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc_word = c;
  endfunction

  function automatic logic [BCNT_W-1:0] bcnt_dec(input logic [BCNT_W-1:0] b);
    bcnt_dec = (b < BCNT_STEP) ? BCNT_ZERO : b - BCNT_STEP;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the transfer context

  wire clear_req = soft_reset_set || begin_auto_transfer;
  wire auto_mode = (xfer_mode != UOF_MANUAL);
  wire udma_read = (xfer_mode == UOF_UDMA) && xfer_is_read;
  wire running = (state_r == UOF_RUN);
  wire count_reached = (remain_r == BCNT_ZERO);

  wire rx_take = running && auto_mode && xfer_is_read && rx_valid;
  wire rx_keep = rx_take && !count_reached;
  wire rx_surplus = rx_take && count_reached && udma_read;
  // Words still wanted spill into the holding buffer while the FIFO is full
  wire to_hold = rx_keep && (sector_fifo_full || (hb.level != LEVEL_EMPTY));
  wire direct = rx_keep && !to_hold;
  wire hold_over = to_hold && (hb.level == LEVEL_FULL);
  wire drain = hb.head_ok && !sector_fifo_full && !direct;

  wire write_auto = running && auto_mode && !xfer_is_read;
  wire spill_evt = write_auto && stop_seen_r && tx_word_strobe
                   && (spill_cnt_r == WSPILL_LIMIT);
  wire hold_evt = auto_mode && (hold_over || spill_evt);
  wire sync_evt = running && udma_read && sync_buffer_overrun;
  wire burst_done = running && udma_read && udma_burst_end;

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer control

  assign hb.push = to_hold;
  assign hb.push_data = rx_word;
  assign hb.pop = drain;
  assign hb.clear = clear_req;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UOF_IDLE: begin
        if (begin_auto_transfer) begin
          state_nxt = UOF_RUN;
        end
      end
      UOF_RUN: begin
        if (soft_reset_set) begin
          state_nxt = UOF_IDLE;
        end else if (burst_done) begin
          state_nxt = UOF_ENDED;
        end
      end
      UOF_ENDED: begin
        if (begin_auto_transfer) begin
          state_nxt = UOF_RUN;
        end else if (soft_reset_set) begin
          state_nxt = UOF_IDLE;
        end
      end
      default: begin
        state_nxt = UOF_IDLE;
      end
    endcase
  end

  assign remain_nxt = begin_auto_transfer ? expected_bytes :
                      rx_keep ? bcnt_dec(remain_r) : remain_r;
  assign stop_seen_nxt = clear_req ? 1'b0 : (stop_seen_r || (write_auto && drive_stop_request));
  // Words the engine still sends after a stop request, saturating at the limit
  assign spill_cnt_nxt = clear_req ? WSPILL_ZERO :
                         (write_auto && stop_seen_r && tx_word_strobe
                          && spill_cnt_r != WSPILL_LIMIT) ? spill_cnt_r + WSPILL_ONE :
                         spill_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // CRC over every word received in a UDMA read, surplus words included

  assign crc_nxt = begin_auto_transfer ? CRC_SEED :
                   (rx_take && udma_read) ? crc_word(crc_r, rx_word) : crc_r;
  // Surplus words are in the sum, so a drive that stopped at termination matches
  assign crc_error_nxt = clear_req ? 1'b0 :
                         burst_done ? (crc_r != drive_crc) : crc_error_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; an event in the clearing cycle wins

  assign hold_ovf_nxt = hold_evt ? 1'b1 :
                        (clear_req ? 1'b0 : hold_ovf_r);
  assign sync_err_nxt = sync_evt ? 1'b1 :
                        (clear_req ? 1'b0 : sync_err_r);
  assign surplus_nxt = rx_surplus ? 1'b1 :
                       (clear_req ? 1'b0 : surplus_r);
  assign surplus_cnt_nxt = clear_req ? (rx_surplus ? SURPLUS_ONE : SURPLUS_ZERO) :
                           (rx_surplus && surplus_cnt_r != SURPLUS_MAX) ?
                           surplus_cnt_r + SURPLUS_ONE : surplus_cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= UOF_IDLE;
      remain_r <= BCNT_ZERO;
      stop_seen_r <= 1'b0;
      spill_cnt_r <= WSPILL_ZERO;
      crc_r <= CRC_SEED;
      crc_error_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      remain_r <= remain_nxt;
      stop_seen_r <= stop_seen_nxt;
      spill_cnt_r <= spill_cnt_nxt;
      crc_r <= crc_nxt;
      crc_error_r <= crc_error_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ovf_r <= FLAG_RESET;
      sync_err_r <= FLAG_RESET;
      surplus_r <= FLAG_RESET;
      surplus_cnt_r <= SURPLUS_ZERO;
    end else begin
      hold_ovf_r <= hold_ovf_nxt;
      sync_err_r <= sync_err_nxt;
      surplus_r <= surplus_nxt;
      surplus_cnt_r <= surplus_cnt_nxt;
    end
  end

  // Surplus words never reach the FIFO path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_wr_r <= 1'b0;
      fifo_data_r <= WORD_ZERO;
    end else begin
      fifo_wr_r <= direct || drain;
      fifo_data_r <= direct ? rx_word : (drain ? hb.head_data : fifo_data_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sector_fifo_wr = fifo_wr_r;
  assign sector_fifo_wr_data = fifo_data_r;
  assign surplus_word_count = surplus_cnt_r;
  assign crc_error = crc_error_r;
  assign transfer_error_status = {RSVD_VALUE, surplus_r, sync_err_r, hold_ovf_r,
                                  LOW_BITS_VALUE};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_hold_ovf_set: assert property (
    hold_over |=> transfer_error_status[BIT_HOLD_OVF])
    else $error("holding overflow did not set flag");

  a_hold_ovf_sticky: assert property (
    transfer_error_status[BIT_HOLD_OVF] && !clear_req |=> transfer_error_status[BIT_HOLD_OVF])
    else $error("holding overflow flag dropped without clear");

  a_flags_clear: assert property (
    clear_req && !hold_evt && !sync_evt && !rx_surplus
    |=> transfer_error_status[BIT_SURPLUS:BIT_HOLD_OVF] == 3'h0
        && surplus_word_count == SURPLUS_ZERO)
    else $error("flags not cleared by control write");

  a_sync_set: assert property (
    sync_buffer_overrun && running && udma_read |=> transfer_error_status[BIT_SYNC_ERR])
    else $error("sync overrun did not set flag");

  a_sync_udma_only: assert property (
    !transfer_error_status[BIT_SYNC_ERR] && !(running && udma_read)
    |=> !transfer_error_status[BIT_SYNC_ERR])
    else $error("sync flag set outside UDMA read");

  a_surplus_count: assert property (
    rx_surplus && !clear_req && surplus_word_count != SURPLUS_MAX
    |=> surplus_word_count == $past(surplus_word_count) + SURPLUS_ONE
        && transfer_error_status[BIT_SURPLUS])
    else $error("surplus word not counted");

  a_surplus_dropped: assert property (
    rx_surplus && !hb.head_ok |=> !sector_fifo_wr)
    else $error("surplus word written to sector FIFO");

  a_write_spill: assert property (
    write_auto && stop_seen_r && tx_word_strobe && !clear_req ##1
    (write_auto && tx_word_strobe && !clear_req)[*3] |=> transfer_error_status[BIT_HOLD_OVF])
    else $error("unhonoured stop did not set flag");

  a_crc_match: assert property (
    burst_done && !clear_req && crc_r == drive_crc |=> !crc_error)
    else $error("CRC error reported on matching sum");

  a_sync_sticky: assert property (
    transfer_error_status[BIT_SYNC_ERR] && !clear_req |=> transfer_error_status[BIT_SYNC_ERR])
    else $error("sync flag dropped without clear");

  a_manual_quiet: assert property (
    xfer_mode == UOF_MANUAL && !transfer_error_status[BIT_HOLD_OVF]
    |=> !transfer_error_status[BIT_HOLD_OVF])
    else $error("holding flag set in manual mode");

  a_surplus_sticky: assert property (
    transfer_error_status[BIT_SURPLUS] && !clear_req
    |=> transfer_error_status[BIT_SURPLUS])
    else $error("surplus flag dropped without clear");

  a_fifo_direct: assert property (
    direct
    |=> sector_fifo_wr && sector_fifo_wr_data == $past(rx_word))
    else $error("wanted word not written to sector FIFO");

  a_fifo_full_block: assert property (
    sector_fifo_full
    |=> !sector_fifo_wr)
    else $error("sector FIFO written while full");

  a_surplus_crc: assert property (
    rx_surplus && !begin_auto_transfer
    |=> crc_r == crc_word($past(crc_r), $past(rx_word)))
    else $error("surplus word left out of CRC");

  a_non_udma_quiet: assert property (
    rx_take && count_reached && !udma_read && !transfer_error_status[BIT_SURPLUS]
    |=> !transfer_error_status[BIT_SURPLUS])
    else $error("surplus flag set outside UDMA read");

  a_idle_ignored: assert property (
    !running && !transfer_error_status[BIT_SURPLUS]
    |=> !transfer_error_status[BIT_SURPLUS])
    else $error("surplus flag set outside a transfer");

  a_crc_seed: assert property (
    begin_auto_transfer
    |=> crc_r == CRC_SEED)
    else $error("CRC not seeded at transfer start");

  a_stop_before_limit: assert property (
    write_auto && !stop_seen_r && !transfer_error_status[BIT_HOLD_OVF]
    |=> !transfer_error_status[BIT_HOLD_OVF])
    else $error("holding flag set on write without stop request");

  a_crc_error_hold: assert property (
    !burst_done && !clear_req
    |=> crc_error == $past(crc_error))
    else $error("CRC error changed outside burst end");

  a_count_load: assert property (
    begin_auto_transfer
    |=> remain_r == $past(expected_bytes))
    else $error("expected byte count not loaded");

  a_hold_ovf_quiet: assert property (
    !hold_evt && !transfer_error_status[BIT_HOLD_OVF]
    |=> !transfer_error_status[BIT_HOLD_OVF])
    else $error("holding flag set without overflow");

  c_surplus_seen: cover property (rx_surplus ##1 burst_done);
  c_write_spill: cover property (spill_evt);
  c_hold_overflow: cover property (hold_over);
  c_hold_drain: cover property (to_hold ##[1:20] drain);
  c_sync_error: cover property (sync_evt);
endmodule

//--- uof_drive_model.sv
// Behavioural drive that bursts read words and reports its running CRC
`timescale 1ns/100ps
module uof_drive_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [uof_pkg::WORD_W-1:0] rx_word,
  output logic [uof_pkg::WORD_W-1:0] drive_crc
);
  import uof_pkg::*;
  logic [WORD_W-1:0] crc_r;
  logic [WORD_W-1:0] corrupt;
  assign drive_crc = crc_r ^ corrupt;
  initial begin
    rx_valid = 1'b0;
    rx_word = 16'hA5A5;
    crc_r = CRC_SEED;
    corrupt = WORD_ZERO;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [WORD_W-1:0] crc_step(input logic [WORD_W-1:0] c,
                                                 input logic [WORD_W-1:0] d);
    logic fb;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      fb = c[WORD_W-1] ^ d[i];
      c = {c[WORD_W-2:0], 1'b0} ^ (fb ? CRC_POLY : WORD_ZERO);
    end
    return c;
  endfunction
  // New burst restarts the running CRC and drops any injected fault
  task automatic open_burst();
    crc_r = CRC_SEED;
    corrupt = WORD_ZERO;
  endtask
  // Caller stands just after a rising edge; the bus idles on the inverse word
  task automatic send_word(input logic [WORD_W-1:0] w, input int gap);
    rx_valid <= 1'b1;
    rx_word <= w;
    crc_r = crc_step(crc_r, w);
    @(posedge clk);
    if (gap != 0) begin
      rx_valid <= 1'b0;
      rx_word <= ~w;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

//--- udma_read_overrun_flags_test.sv
// Self-checking bench of the overrun, sync-error and surplus flags
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module udma_read_overrun_flags_test;
  import uof_pkg::*;
  localparam logic [5:0] C_SOFT = 6'h01;
  localparam logic [5:0] C_BEGIN = 6'h02;
  localparam logic [5:0] C_SYNC = 6'h04;
  localparam logic [5:0] C_STOP = 6'h08;
  localparam logic [5:0] C_TX = 6'h10;
  localparam logic [5:0] C_END = 6'h20;
  logic clk, rst, xfer_is_read, sector_fifo_full, rx_valid, sector_fifo_wr, crc_error, u;
  logic soft_reset_set, begin_auto_transfer, sync_buffer_overrun, drive_stop_request;
  logic tx_word_strobe, udma_burst_end;
  logic [5:0] ctl;
  uof_mode_t xfer_mode;
  logic [BCNT_W-1:0] expected_bytes;
  logic [WORD_W-1:0] rx_word, drive_crc, sector_fifo_wr_data;
  logic [STAT_W-1:0] transfer_error_status;
  logic [SURPLUS_W-1:0] surplus_word_count;
  logic [WORD_W-1:0] q[$];
  int mismatches, checks, cycles, n, s;
  assign soft_reset_set = ctl[0];
  assign begin_auto_transfer = ctl[1];
  assign sync_buffer_overrun = ctl[2];
  assign drive_stop_request = ctl[3];
  assign tx_word_strobe = ctl[4];
  assign udma_burst_end = ctl[5];
  uof_flags dut (.clk(clk), .rst(rst), .soft_reset_set(soft_reset_set),
    .begin_auto_transfer(begin_auto_transfer), .xfer_mode(xfer_mode),
    .xfer_is_read(xfer_is_read), .expected_bytes(expected_bytes), .rx_valid(rx_valid),
    .rx_word(rx_word), .sector_fifo_full(sector_fifo_full),
    .sync_buffer_overrun(sync_buffer_overrun), .drive_stop_request(drive_stop_request),
    .tx_word_strobe(tx_word_strobe), .udma_burst_end(udma_burst_end),
    .drive_crc(drive_crc), .sector_fifo_wr(sector_fifo_wr),
    .sector_fifo_wr_data(sector_fifo_wr_data),
    .transfer_error_status(transfer_error_status),
    .surplus_word_count(surplus_word_count), .crc_error(crc_error));
  uof_drive_model drv (.clk(clk), .rx_valid(rx_valid), .rx_word(rx_word),
    .drive_crc(drive_crc));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Every word written to the sector FIFO must be the oldest noted word
  always @(negedge clk) begin
    if (rst === 1'b0 && sector_fifo_wr === 1'b1) begin
      if (q.size() == 0) `CHK(sector_fifo_wr, 1'b0)
      else `CHK(sector_fifo_wr_data, q.pop_front())
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ctl <= m;
    @(posedge clk);
    ctl <= 6'h00;
  endtask
  task automatic start(input uof_mode_t m, input logic rd, input int nbytes);
    @(posedge clk);
    xfer_mode <= m;
    xfer_is_read <= rd;
    expected_bytes <= nbytes[BCNT_W-1:0];
    drv.open_burst();
    pulse(C_BEGIN);
  endtask
  // Sends k random words; the first keep of them are due in the sector FIFO
  task automatic burst(input int k, input int keep, input int gap);
    logic [31:0] tmp;
    @(posedge clk);
    for (int i = 0; i < k; i++) begin
      tmp = $urandom;
      if (i < keep) q.push_back(tmp[WORD_W-1:0]);
      drv.send_word(tmp[WORD_W-1:0], (i == k - 1) ? 1 : gap);
    end
  endtask
  task automatic expect_flags(input logic [STAT_W-1:0] st, input logic [SURPLUS_W-1:0] c);
    @(negedge clk);
    `CHK(transfer_error_status, st)
    `CHK(surplus_word_count, c)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7c5c));
    rst = 1'b1;
    ctl = 6'h00;
    xfer_mode = UOF_MANUAL;
    xfer_is_read = 1'b0;
    expected_bytes = BCNT_ZERO;
    sector_fifo_full = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    expect_flags(8'h00, 8'h00);
    `CHK(crc_error, 1'b0)
    // One surplus word and a sync overrun in each mode
    for (int m = 0; m < 4; m++) begin
      start(uof_mode_t'(m), 1'b1, 2);
      burst(2, (m == 0) ? 0 : 1, 0);
      pulse(C_SYNC);
      u = (m == 3);
      expect_flags({1'b0, u, u, 5'h00}, {7'h00, u});
      pulse(m[0] ? C_SOFT : C_BEGIN);
      expect_flags(8'h00, 8'h00);
    end
    // Surplus words still enter the CRC
    n = 1 + $urandom_range(3);
    s = 1 + $urandom_range(2);
    start(UOF_UDMA, 1'b1, 2 * n);
    burst(n + s, n, 0);
    expect_flags(8'h40, 8'(s));
    pulse(C_END);
    @(negedge clk);
    `CHK(crc_error, 1'b0)
    start(UOF_UDMA, 1'b1, 4);
    burst(2, 2, 1);
    drv.corrupt = 16'h0100;
    pulse(C_END);
    @(negedge clk);
    `CHK(crc_error, 1'b1)
    pulse(C_SOFT);
    @(negedge clk);
    `CHK(crc_error, 1'b0)
    // Holding buffer takes three words while the FIFO is full, the fourth overflows
    start(UOF_MWDMA, 1'b1, 16);
    sector_fifo_full <= 1'b1;
    burst(3, 3, 1);
    expect_flags(8'h00, 8'h00);
    burst(1, 0, 0);
    expect_flags(8'h10, 8'h00);
    @(posedge clk);
    sector_fifo_full <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK(q.size(), 0)
    pulse(C_SYNC);
    expect_flags(8'h10, 8'h00);
    pulse(C_BEGIN);
    expect_flags(8'h00, 8'h00);
    // Write spill counts only strobes after a stop request
    start(UOF_UDMA, 1'b0, 16);
    repeat (4) pulse(C_TX);
    pulse(C_STOP);
    repeat (3) pulse(C_TX);
    expect_flags(8'h00, 8'h00);
    pulse(C_TX);
    expect_flags(8'h10, 8'h00);
    pulse(C_SOFT);
    expect_flags(8'h00, 8'h00);
    // Four back-to-back strobes after a stop request
    start(UOF_UDMA, 1'b0, 16);
    pulse(C_STOP);
    @(posedge clk);
    ctl <= C_TX;
    repeat (3) @(posedge clk);
    expect_flags(8'h00, 8'h00);
    @(posedge clk);
    ctl <= 6'h00;
    expect_flags(8'h10, 8'h00);
    close_out();
  end
endmodule
